// *** inc/gie_pkg.sv ***
package gie_pkg;

	// Printed register indices; the byte address on the bus is four times the index.
	localparam logic [15:0] PORT_B_INPUT_GATE_IDX = 16'h30b9;
	localparam logic [15:0] PORT_C_INPUT_GATE_IDX = 16'h30ba;
	localparam logic [15:0] PORT_D_INPUT_GATE_IDX = 16'h30bb;
	// Read-only view of the gated pin levels, one byte per port.
	localparam logic [15:0] PIN_LEVEL_VIEW_IDX = 16'h30c0;

	// Width of the byte address seen by the slave.
	localparam int ADDR_WIDTH = 18;
	// Number of pins in each port.
	localparam int PIN_COUNT = 8;
	// Number of gated ports in this bank.
	localparam int PORT_COUNT = 3;

	// Value after reset of every input gate.
	localparam logic [7:0] GATE_RESET = 8'h00;
	// Response codes of the bus.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Register selector produced by the address decoder.
	typedef enum logic [4:0] {
		SEL_NONE = 5'h01,
		SEL_B = 5'h02,
		SEL_C = 5'h04,
		SEL_D = 5'h08,
		SEL_VIEW = 5'h10
	} gie_sel_type;

	// Write channel states, one-hot.
	typedef enum logic [1:0] {
		WR_IDLE = 2'h1,
		WR_RESP = 2'h2
	} gie_wr_state_type;

	// Read channel states, one-hot.
	typedef enum logic [1:0] {
		RD_IDLE = 2'h1,
		RD_RESP = 2'h2
	} gie_rd_state_type;

	// The three input gates travel together, port B in the low byte.
	typedef struct packed {
		logic [7:0] port_d;
		logic [7:0] port_c;
		logic [7:0] port_b;
	} gie_gates_type;

endpackage

// *** src/gie_ports.sv ***
// Overview of operation
// - Port B input gate register at 0x30B9.
// - Port C input gate register at 0x30BA.
// - Port D input gate register at 0x30BB.
// - Bit one enables pin input, zero disables.
// - All gate bits writable and read back.
// - Reset clears every gate bit to zero.
//
// Implementation choice: register access over AXI4-Lite.
module gie_ports #(
	parameter int PIN_COUNT = gie_pkg::PIN_COUNT
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [gie_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [gie_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [PIN_COUNT-1:0] port_b_pad,
	input wire logic [PIN_COUNT-1:0] port_c_pad,
	input wire logic [PIN_COUNT-1:0] port_d_pad,
	output logic [PIN_COUNT-1:0] port_b_pin_in,
	output logic [PIN_COUNT-1:0] port_c_pin_in,
	output logic [PIN_COUNT-1:0] port_d_pin_in
);

	// The logic is built for exactly one byte per port.
	if (PIN_COUNT != 8) begin : g_check
		$error("gie_ports serves only eight pins per port.");
	end

	// Maps a byte address onto the register it selects.
	function automatic gie_pkg::gie_sel_type decode(input logic [gie_pkg::ADDR_WIDTH-1:0] addr);
		logic [15:0] idx;
		idx = addr[gie_pkg::ADDR_WIDTH-1:2];
		if (addr[1:0] != 2'h0) begin
			decode = gie_pkg::SEL_NONE;
		end else if (idx == gie_pkg::PORT_B_INPUT_GATE_IDX) begin
			decode = gie_pkg::SEL_B;
		end else if (idx == gie_pkg::PORT_C_INPUT_GATE_IDX) begin
			decode = gie_pkg::SEL_C;
		end else if (idx == gie_pkg::PORT_D_INPUT_GATE_IDX) begin
			decode = gie_pkg::SEL_D;
		end else if (idx == gie_pkg::PIN_LEVEL_VIEW_IDX) begin
			decode = gie_pkg::SEL_VIEW;
		end else begin
			decode = gie_pkg::SEL_NONE;
		end
	endfunction

	gie_pkg::gie_gates_type gates_reg; // The three input gate registers.
	gie_pkg::gie_gates_type gated_reg; // Pin levels after the gate.
	logic [3*PIN_COUNT-1:0] pad_all; // All pads packed, port B lowest.
	logic [3*PIN_COUNT-1:0] level_all; // Accepted pad levels, port B lowest.
	gie_pkg::gie_wr_state_type wr_state_reg; // Write channel state.
	gie_pkg::gie_rd_state_type rd_state_reg; // Read channel state.
	logic aw_got_reg; // Write address has been taken.
	logic w_got_reg; // Write data has been taken.
	logic [gie_pkg::ADDR_WIDTH-1:0] awaddr_reg; // Held write address.
	logic [31:0] wdata_reg; // Held write data.
	logic [3:0] wstrb_reg; // Held write strobes.
	gie_pkg::gie_sel_type wr_sel; // Register chosen by the held write address.

	assign pad_all = {port_d_pad, port_c_pad, port_b_pad};
	assign wr_sel = decode(awaddr_reg);

	// Each pad passes three flip-flops; a level is accepted once the last two agree.
	for (genvar i = 0; i < 3 * PIN_COUNT; i++) begin : g_pin
		logic s1_reg; // First stage, read only by the second.
		logic s2_reg; // Second stage.
		logic s3_reg; // Third stage.
		logic level_reg; // Accepted pad level.
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				s1_reg <= 1'b0;
				s2_reg <= 1'b0;
				s3_reg <= 1'b0;
				level_reg <= 1'b0;
			end else begin
				s1_reg <= pad_all[i];
				s2_reg <= s1_reg;
				s3_reg <= s2_reg;
				// The level moves only when the two later stages agree.
				if (s2_reg == s3_reg) begin
					level_reg <= s3_reg;
				end
			end
		end
		// Hands the accepted level to the shared gate stage.
		assign level_all[i] = level_reg;
	end

	// A clear gate forces zero, a set gate passes the pad level; one process owns the word.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gated_reg <= '0;
		end else begin
			gated_reg <= gie_pkg::gie_gates_type'(level_all & gates_reg);
		end
	end

	// Gated levels drive the internal pin inputs straight from flip-flops.
	assign port_b_pin_in = gated_reg.port_b;
	assign port_c_pin_in = gated_reg.port_c;
	assign port_d_pin_in = gated_reg.port_d;

	// Write channel: takes address and data in either order, then answers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_reg <= gie_pkg::WR_IDLE;
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= gie_pkg::RESP_OKAY;
			awaddr_reg <= '0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end else begin
			case (wr_state_reg)
				gie_pkg::WR_IDLE: begin
					// Ready rises one cycle after release and falls once each item is taken.
					if (s_axi_awvalid && s_axi_awready) begin
						awaddr_reg <= s_axi_awaddr;
						aw_got_reg <= 1'b1;
						s_axi_awready <= 1'b0;
					end else begin
						s_axi_awready <= !aw_got_reg;
					end
					if (s_axi_wvalid && s_axi_wready) begin
						wdata_reg <= s_axi_wdata;
						wstrb_reg <= s_axi_wstrb;
						w_got_reg <= 1'b1;
						s_axi_wready <= 1'b0;
					end else begin
						s_axi_wready <= !w_got_reg;
					end
					// Both halves held: answer; unmapped or read-only targets get an error.
					if (aw_got_reg && w_got_reg) begin
						s_axi_bvalid <= 1'b1;
						if (wr_sel == gie_pkg::SEL_B || wr_sel == gie_pkg::SEL_C ||
							wr_sel == gie_pkg::SEL_D) begin
							s_axi_bresp <= gie_pkg::RESP_OKAY;
						end else begin
							s_axi_bresp <= gie_pkg::RESP_SLVERR;
						end
						wr_state_reg <= gie_pkg::WR_RESP;
					end
				end
				gie_pkg::WR_RESP: begin
					// The response stands until the master takes it.
					if (s_axi_bready) begin
						s_axi_bvalid <= 1'b0;
						aw_got_reg <= 1'b0;
						w_got_reg <= 1'b0;
						s_axi_awready <= 1'b1;
						s_axi_wready <= 1'b1;
						wr_state_reg <= gie_pkg::WR_IDLE;
					end
				end
				default: begin
					wr_state_reg <= gie_pkg::WR_IDLE;
				end
			endcase
		end
	end

	// Gate registers take the low byte when its strobe is set.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gates_reg <= {gie_pkg::GATE_RESET, gie_pkg::GATE_RESET, gie_pkg::GATE_RESET};
		end else if (wr_state_reg == gie_pkg::WR_IDLE && aw_got_reg && w_got_reg &&
			wstrb_reg[0]) begin
			if (wr_sel == gie_pkg::SEL_B) begin
				gates_reg.port_b <= wdata_reg[7:0];
			end else if (wr_sel == gie_pkg::SEL_C) begin
				gates_reg.port_c <= wdata_reg[7:0];
			end else if (wr_sel == gie_pkg::SEL_D) begin
				gates_reg.port_d <= wdata_reg[7:0];
			end
		end
	end

	// Read channel: one read at a time, data captured when the address is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_reg <= gie_pkg::RD_IDLE;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= gie_pkg::RESP_OKAY;
		end else begin
			case (rd_state_reg)
				gie_pkg::RD_IDLE: begin
					if (s_axi_arvalid && s_axi_arready) begin
						s_axi_arready <= 1'b0;
						s_axi_rvalid <= 1'b1;
						s_axi_rresp <= gie_pkg::RESP_OKAY;
						rd_state_reg <= gie_pkg::RD_RESP;
						case (decode(s_axi_araddr))
							gie_pkg::SEL_B: s_axi_rdata <= {24'h00_0000, gates_reg.port_b};
							gie_pkg::SEL_C: s_axi_rdata <= {24'h00_0000, gates_reg.port_c};
							gie_pkg::SEL_D: s_axi_rdata <= {24'h00_0000, gates_reg.port_d};
							gie_pkg::SEL_VIEW: s_axi_rdata <= {8'h00, gated_reg};
							default: begin
								// Unmapped addresses read zero with an error.
								s_axi_rdata <= 32'h0000_0000;
								s_axi_rresp <= gie_pkg::RESP_SLVERR;
							end
						endcase
					end else begin
						s_axi_arready <= 1'b1;
					end
				end
				gie_pkg::RD_RESP: begin
					// Data stand until the master takes them.
					if (s_axi_rready) begin
						s_axi_rvalid <= 1'b0;
						s_axi_arready <= 1'b1;
						rd_state_reg <= gie_pkg::RD_IDLE;
					end
				end
				default: begin
					rd_state_reg <= gie_pkg::RD_IDLE;
				end
			endcase
		end
	end

endmodule // gie_ports

// *** test/gie_ports_sva.sv ***
module gie_ports_sva #(
	parameter int PIN_COUNT = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [PIN_COUNT-1:0] port_b_pin_in,
	input wire logic [PIN_COUNT-1:0] port_c_pin_in,
	input wire logic [PIN_COUNT-1:0] port_d_pin_in
);
	// All checks share the bus clock and its reset.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// A write answer is one quiet cycle and then the response.
	sequence s_write_answer;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	a_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_write_answer)
		else $error("write response late or early");
	a_write_busy: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
	a_bvalid_release: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write response not released");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read response missing");
	a_rdata_stands: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped while stalled");
	a_read_release: assert property (
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read response not released");
	a_rdata_upper: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00) else $error("read upper byte not zero");
	a_pins_reset: assert property (
		$rose(aresetn) |-> {port_d_pin_in, port_c_pin_in, port_b_pin_in} == '0)
		else $error("pin inputs not cleared by reset");
endmodule // gie_ports_sva

bind gie_ports gie_ports_sva #(.PIN_COUNT(PIN_COUNT)) i_sva (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .port_b_pin_in, .port_c_pin_in, .port_d_pin_in);

// *** test/gie_pad_model.sv ***
// Pin pads: each level settles a few ns after the drive moves, away from any edge.
module gie_pad_model (
	input wire logic [23:0] level,
	output logic [7:0] port_b_pad,
	output logic [7:0] port_c_pad,
	output logic [7:0] port_d_pad
);
	timeunit 1ns;
	timeprecision 1ns;
	assign #7 {port_d_pad, port_c_pad, port_b_pad} = level;
endmodule // gie_pad_model

// *** test/gie_ports_tb.sv ***
module gie_ports_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [17:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] port_b_pad, port_c_pad, port_d_pad, port_b_pin_in, port_c_pin_in, port_d_pin_in;
	logic [23:0] level = 24'h96c35a; // Pad levels driven by the pad model.
	logic [3:0] s_axi_wstrb = 4'hf; // Write strobes, low strobe cleared for one test.
	logic [15:0] idx [3] = '{gie_pkg::PORT_B_INPUT_GATE_IDX, gie_pkg::PORT_C_INPUT_GATE_IDX,
		gie_pkg::PORT_D_INPUT_GATE_IDX};
	logic [7:0] val [3] = '{8'hff, 8'h0f, 8'h81}; // Gate values for B, C and D.
	int failures = 0;
	int check_count = 0;
	initial begin
		forever #20 aclk = ~aclk;
	end
	gie_pad_model i_pads (.level, .port_b_pad, .port_c_pad, .port_d_pad);
	gie_ports i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_b_pad, .port_c_pad,
		.port_d_pad, .port_b_pin_in, .port_c_pin_in, .port_d_pin_in);
	// Compares one value and counts the result.
	task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Writes one word; address and data are released as each is taken.
	task automatic wr_chk(input logic [17:0] a, input logic [31:0] d, input logic [1:0] er);
		logic got;
		got = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!got) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				got = 1;
				s_axi_bready <= 1'b0;
				check_val("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
			end
		end
	endtask
	// Reads one word; ready is raised only after valid is seen, to stall the answer.
	task automatic rd_chk(input logic [17:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic got;
		got = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		while (!got) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				got = 1;
				s_axi_rready <= 1'b0;
				check_val("rdata", ed, s_axi_rdata);
				check_val("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
			end else if (s_axi_rvalid) s_axi_rready <= 1'b1;
		end
	endtask
	// Lets the pad levels settle through the input path, then compares the gated pins.
	task automatic pin_chk(input logic [23:0] exp);
		repeat (8) @(posedge aclk);
		check_val("pins", {8'h0, exp}, {8'h0, port_d_pin_in, port_c_pin_in, port_b_pin_in});
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// About ten thousand cycles, far beyond the few hundred that the tests take.
	initial begin
		#400000;
		failures++;
		tally_and_finish();
	end
	initial begin
		for (int r = 0; r < 2; r++) begin
			aresetn <= 1'b0;
			repeat (6) @(posedge aclk);
			aresetn <= 1'b1;
			repeat (2) @(posedge aclk);
			for (int i = 0; i < 3; i++) rd_chk({idx[i], 2'h0}, 32'h0, 2'h0);
			pin_chk(24'h0);
			for (int i = 0; i < 3; i++) begin
				wr_chk({idx[i], 2'h0}, 32'hffffff00 | val[i], 2'h0);
			end
			for (int i = 0; i < 3; i++) begin
				rd_chk({idx[i], 2'h0}, {24'h0, val[i]}, 2'h0);
			end
			pin_chk(level & {val[2], val[1], val[0]});
			rd_chk({gie_pkg::PIN_LEVEL_VIEW_IDX, 2'h0}, {8'h0, level & 24'h810fff}, 2'h0);
			wr_chk({idx[0], 2'h1}, 32'h0, 2'h2);
			wr_chk(18'h00100, 32'h0, 2'h2);
			rd_chk(18'h00100, 32'h0, 2'h2);
			rd_chk({idx[0], 2'h0}, 32'hff, 2'h0);
			// A write without its low strobe answers OKAY and leaves the gate alone.
			s_axi_wstrb <= 4'he;
			wr_chk({idx[1], 2'h0}, 32'h0, 2'h0);
			s_axi_wstrb <= 4'hf;
			rd_chk({idx[1], 2'h0}, {24'h0, val[1]}, 2'h0);
			level <= ~level;
			wr_chk({idx[0], 2'h0}, 32'h0, 2'h0);
			// The level has already turned over here, so the expectation uses it as it stands.
			pin_chk(level & 24'h810f00);
		end
		tally_and_finish();
	end
endmodule // gie_ports_tb
